// [rtl/cmps_pkg.sv]
package cmps_pkg;

	// Execution modes, encoded in the mode field
	typedef enum logic [2:0] {
		MODE_APP,
		MODE_SUP,
		MODE_INTERRUPT_LEVEL_0_MODE,
		MODE_INTERRUPT_LEVEL_1_MODE,
		MODE_INTERRUPT_LEVEL_2_MODE,
		MODE_INTERRUPT_LEVEL_3_MODE,
		MODE_EXC,
		MODE_NMI
	} cmps_mode_t;

	// Status word, upper half first
	typedef struct packed {
		logic [3:0]  rsv_hi;   // Reserved, read zero
		logic        dm;       // Debug mask
		logic        d;        // Debug state
		logic        rsv_25;   // Reserved
		cmps_mode_t  mode;     // Current mode
		logic        em;       // Exception mask
		logic [3:0]  imask;    // Level masks, bit n masks level n
		logic        gm;       // Global interrupt mask
		logic        r;        // Further control bit
		logic        t;        // Scratch bit
		logic [7:0]  rsv_lo;   // Reserved, read zero
		logic        l;        // Lock
		logic        q;        // Saturation
		logic        v;        // Overflow
		logic        n;        // Sign
		logic        z;        // Zero
		logic        c;        // Carry
	} cmps_status_t;

	// Pending mode requests
	typedef struct packed {
		logic       nmi;       // Non-maskable interrupt
		logic       exc;       // Exception
		logic [3:0] irq;       // Interrupt levels 3..0
	} cmps_req_t;

	// System register byte addresses
	localparam logic [9:0]  SR_ADDR       = 10'h000;
	localparam logic [9:0]  DBG_RSR_ADDR  = 10'h030;
	localparam logic [9:0]  DBG_RAR_ADDR  = 10'h050;
	// Reset: supervisor mode, global and exception masks set, low half zero
	localparam logic [31:0] STATUS_RESET  = 32'h0061_0000;
	localparam logic [31:0] STATUS_WMASK  = 32'h0DFF_C03F;
	localparam logic [31:0] PC_RESET      = 32'h0000_0000;
	// Register file indices
	localparam logic [3:0]  IDX_SP        = 4'hD;
	localparam logic [3:0]  IDX_LR        = 4'hE;
	localparam logic [3:0]  IDX_PC        = 4'hF;
	localparam int          NUM_GPR       = 13;
	// Rank given to modes without a priority
	localparam logic [2:0]  RANK_NONE     = 3'h7;

endpackage

// [rtl/cmps_core.sv]
`timescale 1ns/1ps
`default_nettype none
module cmps_core
	import cmps_pkg::*;
(
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	input  wire cmps_req_t    req_in,
	input  wire logic         scall_in,
	input  wire logic         ret_in,
	input  wire logic [31:0]  ret_status_in,
	input  wire logic         dbg_enter_in,
	input  wire logic         retd_in,
	input  wire logic         priv_instr_in,
	input  wire logic         prot_access_in,
	input  wire logic         flags_we_in,
	input  wire logic [4:0]   flags_in,
	input  wire logic         sysreg_rd_in,
	input  wire logic         sysreg_wr_in,
	input  wire logic [9:0]   sysreg_addr_in,
	input  wire logic [31:0]  sysreg_wdata_in,
	input  wire logic         rf_we_in,
	input  wire logic [3:0]   rf_widx_in,
	input  wire logic [31:0]  rf_wdata_in,
	input  wire logic [3:0]   rf_ridx_in,
	output logic [31:0]       sysreg_rdata_out,
	output logic              sysreg_err_out,
	output logic              priv_fault_out,
	output logic              prot_fault_out,
	output logic [31:0]       rf_rdata_out,
	output logic [31:0]       status_out,
	output logic              privileged_out,
	output logic              take_out,
	output cmps_mode_t        take_mode_out
);

	// Architectural state
	cmps_status_t   status, next_status;            // Status word
	logic [31:0]    dbg_status, next_dbg_status;    // Status saved on debug entry
	logic [31:0]    dbg_addr, next_dbg_addr;        // Return address for debug exit
	logic [31:0]    gpr [NUM_GPR], next_gpr [NUM_GPR]; // General registers
	logic [31:0]    pc, next_pc;                    // Program counter
	logic [31:0]    lr, next_lr;                    // Link register
	logic [31:0]    app_stack_pointer, next_app_stack_pointer;            // Application stack pointer
	logic [31:0]    system_stack_pointer, next_system_stack_pointer;            // System stack pointer
	// Decode helpers
	logic           priv;                   // Privileged now
	logic           enter_dbg, leave_dbg;   // Debug entry and exit this cycle
	logic           take;                   // Mode pre-empted this cycle
	cmps_mode_t     best;                   // Highest pending mode
	logic           best_vld;
	logic [31:0]    next_rdata, next_rf_rdata;
	// Priority rank, smaller is stronger
	function automatic logic [2:0] rank(input cmps_mode_t m);
		case (m)
			MODE_NMI:  rank = 3'h1;
			MODE_EXC:  rank = 3'h2;
			MODE_INTERRUPT_LEVEL_3_MODE: rank = 3'h3;
			MODE_INTERRUPT_LEVEL_2_MODE: rank = 3'h4;
			MODE_INTERRUPT_LEVEL_1_MODE: rank = 3'h5;
			MODE_INTERRUPT_LEVEL_0_MODE: rank = 3'h6;
			default:   rank = RANK_NONE;
		endcase
	endfunction
	// privilege decode
	// Debug state counts as privileged whatever the mode field says
	assign priv      = (status.mode != MODE_APP) || status.d;
	assign enter_dbg = dbg_enter_in && !status.d;
	assign leave_dbg = retd_in && status.d;
	// Pick the strongest pending request; masked levels do not compete
	always_comb
	begin
		best     = MODE_INTERRUPT_LEVEL_0_MODE;
		best_vld = 1'b1;
		if (req_in.nmi) best = MODE_NMI;
		else if (req_in.exc) best = MODE_EXC;
		else if (req_in.irq[3] && !status.gm && !status.imask[3]) best = MODE_INTERRUPT_LEVEL_3_MODE;
		else if (req_in.irq[2] && !status.gm && !status.imask[2]) best = MODE_INTERRUPT_LEVEL_2_MODE;
		else if (req_in.irq[1] && !status.gm && !status.imask[1]) best = MODE_INTERRUPT_LEVEL_1_MODE;
		else if (req_in.irq[0] && !status.gm && !status.imask[0]) best = MODE_INTERRUPT_LEVEL_0_MODE;
		else best_vld = 1'b0;
	end
	assign take = best_vld && (rank(best) < rank(status.mode));
	// Status and debug save registers, next values
	// Debug entry beats everything so a monitor always gets control
	always_comb
	begin
		next_status     = status;
		next_dbg_status = dbg_status;
		next_dbg_addr   = dbg_addr;
		if (enter_dbg)
		begin
			next_dbg_status    = status;
			next_dbg_addr      = pc;
			next_status.d      = 1'b1;
			next_status.imask  = 4'hF;
		end
		else if (leave_dbg)
		begin
			next_status = cmps_status_t'(dbg_status);
		end
		else if (take)
		begin
			next_status.mode = best;
		end
		else if (scall_in && (status.mode == MODE_APP || status.mode == MODE_SUP))
		begin
			next_status.mode = MODE_SUP;
		end
		else if (ret_in && priv)
		begin
			// Return pops the stacked word
			next_status = cmps_status_t'(ret_status_in & STATUS_WMASK);
		end
		else if (sysreg_wr_in && priv)
		begin
			case (sysreg_addr_in)
				SR_ADDR:      next_status     = cmps_status_t'(sysreg_wdata_in & STATUS_WMASK);
				DBG_RSR_ADDR: next_dbg_status = sysreg_wdata_in & STATUS_WMASK;
				DBG_RAR_ADDR: next_dbg_addr   = sysreg_wdata_in;
				default:      next_dbg_addr   = dbg_addr;
			endcase
		end
		else if (flags_we_in)
		begin
			// condition flags from the datapath, any mode
			{next_status.q, next_status.v, next_status.n, next_status.z, next_status.c} =
				flags_in;
		end
	end
	// Status registers
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			status     <= cmps_status_t'(STATUS_RESET);
			dbg_status <= STATUS_RESET;
			dbg_addr   <= PC_RESET;
		end
		else
		begin
			status     <= next_status;
			dbg_status <= next_dbg_status;
			dbg_addr   <= next_dbg_addr;
		end
	end
	// Register file next values
	// Debug exit reloads the program counter from the saved address
	always_comb
	begin
		for (int i = 0; i < NUM_GPR; i++)
			next_gpr[i] = gpr[i];
		next_pc     = pc;
		next_lr     = lr;
		next_app_stack_pointer = app_stack_pointer;
		next_system_stack_pointer = system_stack_pointer;
		if (leave_dbg)
			next_pc = dbg_addr;
		else if (rf_we_in)
		begin
			case (rf_widx_in)
				IDX_PC:  next_pc = rf_wdata_in;
				IDX_LR:  next_lr = rf_wdata_in;
				IDX_SP:
				begin
					if (priv)
						next_system_stack_pointer = rf_wdata_in;
					else
						next_app_stack_pointer = rf_wdata_in;
				end
				default: next_gpr[rf_widx_in] = rf_wdata_in;
			endcase
		end
	end
	// Register file
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			for (int i = 0; i < NUM_GPR; i++)
				gpr[i] <= 32'h0000_0000;
			pc     <= PC_RESET;
			lr     <= 32'h0000_0000;
			app_stack_pointer <= 32'h0000_0000;
			system_stack_pointer <= 32'h0000_0000;
		end
		else
		begin
			for (int i = 0; i < NUM_GPR; i++)
				gpr[i] <= next_gpr[i];
			pc     <= next_pc;
			lr     <= next_lr;
			app_stack_pointer <= next_app_stack_pointer;
			system_stack_pointer <= next_system_stack_pointer;
		end
	end
	// Read data, next values
	// Refused or unmapped reads return zero rather than stale data
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (sysreg_rd_in && priv)
		begin
			case (sysreg_addr_in)
				SR_ADDR:      next_rdata = status;
				DBG_RSR_ADDR: next_rdata = dbg_status;
				DBG_RAR_ADDR: next_rdata = dbg_addr;
				default:      next_rdata = 32'h0000_0000;
			endcase
		end
		case (rf_ridx_in)
			IDX_PC:  next_rf_rdata = pc;
			IDX_LR:  next_rf_rdata = lr;
			IDX_SP:  next_rf_rdata = priv ? system_stack_pointer : app_stack_pointer;
			default: next_rf_rdata = gpr[rf_ridx_in];
		endcase
	end
	// Output registers
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sysreg_rdata_out <= 32'h0000_0000;
			sysreg_err_out   <= 1'b0;
			priv_fault_out   <= 1'b0;
			prot_fault_out   <= 1'b0;
			rf_rdata_out     <= 32'h0000_0000;
			take_out         <= 1'b0;
			take_mode_out    <= MODE_APP;
		end
		else
		begin
			sysreg_rdata_out <= next_rdata;
			sysreg_err_out   <= (sysreg_rd_in || sysreg_wr_in) && !priv;
			priv_fault_out   <= (priv_instr_in || (retd_in && !status.d)) && !priv;
			prot_fault_out   <= prot_access_in && !priv;
			rf_rdata_out     <= next_rf_rdata;
			take_out         <= take && !enter_dbg && !leave_dbg;
			take_mode_out    <= best;
		end
	end

	assign status_out     = status;
	assign privileged_out = priv;

	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	logic seen_edge;                        // Low only in first cycle after reset
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			seen_edge <= 1'b0;
		else
			seen_edge <= 1'b1;
	end

	a_reset_lower_zero: assert property (!seen_edge |-> status[15:0] == 16'h0000)
		else $error("low half not zero after reset");
	a_reset_supervisor: assert property (!seen_edge |-> status.mode == MODE_SUP)
		else $error("not supervisor after reset");
	a_preempt_higher: assert property (take_out |-> rank(take_mode_out) < rank($past(status.mode)) && status.mode == take_mode_out)
		else $error("pre-emption by weaker mode");
	a_no_lower_preempt: assert property ((status.mode == MODE_NMI) && !dbg_enter_in && !retd_in && !ret_in && !sysreg_wr_in |=> status.mode == MODE_NMI)
		else $error("nmi mode left by weaker request");
	a_app_refuse: assert property ((sysreg_rd_in || sysreg_wr_in) && status.mode == MODE_APP && !status.d |=> sysreg_err_out && sysreg_rdata_out == 32'h0000_0000)
		else $error("application system access not refused");
	a_debug_masks: assert property (dbg_enter_in && !status.d |=> status.d && status.imask == 4'hF ##1 !priv_fault_out)
		else $error("debug entry did not mask levels");
	a_retd_restore: assert property (retd_in && status.d |=> status == $past(dbg_status) && pc == $past(dbg_addr))
		else $error("debug return did not restore");
	a_sp_banked: assert property (rf_ridx_in == IDX_SP && !priv |=> rf_rdata_out == $past(app_stack_pointer))
		else $error("wrong stack pointer bank");
	a_prot_fault: assert property (prot_access_in && !priv |=> prot_fault_out)
		else $error("protected access not refused");
	a_debug_priv: assert property (status.d && priv_instr_in |=> !priv_fault_out)
		else $error("privileged instruction refused in debug");

endmodule
`default_nettype wire

// [test/cpu_mode_privilege_status_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_privilege_status_tb;
	import cmps_pkg::*;

	// Bench-driven inputs
	logic        clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	cmps_req_t   req_in = '0;
	logic        scall_in = 1'b0, ret_in = 1'b0, dbg_enter_in = 1'b0, retd_in = 1'b0;
	logic        priv_instr_in = 1'b0, prot_access_in = 1'b0, flags_we_in = 1'b0;
	logic [31:0] ret_status_in = '0;
	logic [4:0]  flags_in = '0;
	logic        sysreg_rd_in = 1'b0, sysreg_wr_in = 1'b0, rf_we_in = 1'b0;
	logic [9:0]  sysreg_addr_in = '0;
	logic [31:0] sysreg_wdata_in = '0, rf_wdata_in = '0;
	logic [3:0]  rf_widx_in = '0, rf_ridx_in = '0;
	// Observed outputs
	logic [31:0] sysreg_rdata_out, rf_rdata_out, status_out;
	logic        sysreg_err_out, priv_fault_out, prot_fault_out, privileged_out, take_out;
	cmps_mode_t  take_mode_out;
	// Scoreboard
	int          errors = 0, n_compared = 0, cycles = 0;
	logic [5:0]  req_tab [6] = '{6'h02, 6'h03, 6'h0B, 6'h1B, 6'h3B, 6'h3B};
	logic        take_tab [6] = '{1, 0, 1, 1, 1, 0};
	cmps_mode_t  mode_tab [6] = '{MODE_INTERRUPT_LEVEL_1_MODE, MODE_INTERRUPT_LEVEL_1_MODE, MODE_INTERRUPT_LEVEL_3_MODE, MODE_EXC, MODE_NMI, MODE_NMI};

	cmps_core u_cmps_core (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req_in),
		.scall_in(scall_in), .ret_in(ret_in), .ret_status_in(ret_status_in),
		.dbg_enter_in(dbg_enter_in), .retd_in(retd_in), .priv_instr_in(priv_instr_in),
		.prot_access_in(prot_access_in), .flags_we_in(flags_we_in), .flags_in(flags_in),
		.sysreg_rd_in(sysreg_rd_in), .sysreg_wr_in(sysreg_wr_in),
		.sysreg_addr_in(sysreg_addr_in), .sysreg_wdata_in(sysreg_wdata_in),
		.rf_we_in(rf_we_in), .rf_widx_in(rf_widx_in), .rf_wdata_in(rf_wdata_in),
		.rf_ridx_in(rf_ridx_in), .sysreg_rdata_out(sysreg_rdata_out),
		.sysreg_err_out(sysreg_err_out), .priv_fault_out(priv_fault_out),
		.prot_fault_out(prot_fault_out), .rf_rdata_out(rf_rdata_out),
		.status_out(status_out), .privileged_out(privileged_out), .take_out(take_out),
		.take_mode_out(take_mode_out));

	// 50 MHz clock
	always #10 clk_in = ~clk_in;

	// Hang guard: the whole sequence needs well under 300 cycles
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One edge that samples the request; pulses drop at it, outputs settle after
	task automatic tick();
		@(posedge clk_in);
		{scall_in, ret_in, dbg_enter_in, retd_in, priv_instr_in, prot_access_in} <= '0;
		{flags_we_in, sysreg_rd_in, sysreg_wr_in, rf_we_in} <= '0;
		#1;
	endtask

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk_in);
		sysreg_wr_in <= 1'b1;
		sysreg_addr_in <= a;
		sysreg_wdata_in <= d;
		tick();
	endtask

	task automatic rd(input logic [9:0] a);
		@(posedge clk_in);
		sysreg_rd_in <= 1'b1;
		sysreg_addr_in <= a;
		tick();
	endtask

	// Single-cycle events: 0 call, 1 debug entry, 2 debug return, 3 priv, 4 prot, 5 flags, 6 ret
	task automatic ev(input int k);
		@(posedge clk_in);
		case (k)
			0: scall_in <= 1'b1;
			1: dbg_enter_in <= 1'b1;
			2: retd_in <= 1'b1;
			3: priv_instr_in <= 1'b1;
			4: prot_access_in <= 1'b1;
			6: ret_in <= 1'b1;
			default: flags_we_in <= 1'b1;
		endcase
		tick();
	endtask

	task automatic rf(input logic we, input logic [3:0] i, input logic [31:0] d);
		@(posedge clk_in);
		rf_we_in <= we;
		rf_widx_in <= i;
		rf_wdata_in <= d;
		rf_ridx_in <= i;
		tick();
		tick();
	endtask

	initial
	begin
		repeat (20) @(posedge clk_in);
		rstn_in <= 1'b1;
		tick();
		chk("status after reset", STATUS_RESET, status_out);
		chk("privileged after reset", 32'h0000_0001, 32'(privileged_out));
		$display("test reset done");
		wr(SR_ADDR, 32'h0040_0000);
		chk("status write", 32'h0040_0000, status_out);
		flags_in <= 5'h15;
		ev(5);
		chk("flag update", 32'h0040_0015, status_out);
		rd(10'h004);
		chk("unmapped err", 32'h0000_0000, 32'(sysreg_err_out));
		rf(1'b1, IDX_SP, 32'h1234_5678);
		chk("system stack", 32'h1234_5678, rf_rdata_out);
		$display("test access done");
		// Strict priority: equal or lower rank never pre-empts
		for (int k = 0; k < 6; k++)
		begin
			@(posedge clk_in);
			req_in <= req_tab[k];
			tick();
			chk("take", 32'(take_tab[k]), 32'(take_out));
			chk("mode", 32'(mode_tab[k]), 32'(status_out[24:22]));
			chk("take mode", 32'(mode_tab[k]), 32'(take_mode_out));
		end
		@(posedge clk_in);
		req_in <= '0;
		$display("test priority done");
		wr(SR_ADDR, 32'h0000_0000);
		chk("app unprivileged", 32'h0000_0000, 32'(privileged_out));
		rd(SR_ADDR);
		chk("app read err", 32'h0000_0001, 32'(sysreg_err_out));
		chk("app read data", 32'h0000_0000, sysreg_rdata_out);
		wr(SR_ADDR, 32'h0040_0000);
		chk("app write dropped", 32'h0000_0000, status_out);
		ev(3);
		chk("priv fault", 32'h0000_0001, 32'(priv_fault_out));
		ev(4);
		chk("prot fault", 32'h0000_0001, 32'(prot_fault_out));
		rf(1'b1, IDX_SP, 32'h0BAD_0001);
		chk("app stack", 32'h0BAD_0001, rf_rdata_out);
		$display("test application done");
		ev(1);
		chk("debug masks", 32'h041E_0000, status_out);
		rd(SR_ADDR);
		chk("debug read", 32'h041E_0000, sysreg_rdata_out);
		wr(SR_ADDR, 32'h041C_0000);
		chk("debug unmask", 32'h041C_0000, status_out);
		ev(2);
		chk("debug return", 32'h0000_0000, status_out);
		ev(0);
		chk("call to sup", 32'h0040_0000, status_out);
		rf(1'b0, IDX_SP, 32'h0000_0000);
		chk("banked stack", 32'h1234_5678, rf_rdata_out);
		$display("test debug done");
		// Global mask, then level mask, hold off a level 3 request
		wr(SR_ADDR, 32'h0041_0000);
		@(posedge clk_in);
		req_in <= 6'h08;
		tick();
		chk("gm blocks", 32'h0000_0000, 32'(take_out));
		wr(SR_ADDR, 32'h0050_0000);
		tick();
		chk("imask blocks", 32'h0000_0000, 32'(take_out));
		chk("imask mode", 32'(MODE_SUP), 32'(status_out[24:22]));
		wr(SR_ADDR, 32'h0040_0000);
		tick();
		chk("unmasked take", 32'h0000_0001, 32'(take_out));
		chk("unmasked mode", 32'(MODE_INTERRUPT_LEVEL_3_MODE), 32'(status_out[24:22]));
		@(posedge clk_in);
		req_in <= '0;
		ret_status_in <= 32'hFFFF_FFFF;
		ev(6);
		chk("ret reserved zero", 32'h0DFF_C03F, status_out);
		wr(DBG_RAR_ADDR, 32'h0000_0100);
		rd(DBG_RAR_ADDR);
		chk("debug addr read", 32'h0000_0100, sysreg_rdata_out);
		rd(DBG_RSR_ADDR);
		chk("debug status read", 32'h0000_0000, sysreg_rdata_out);
		ev(2);
		chk("retd status", 32'h0000_0000, status_out);
		rf(1'b0, IDX_PC, 32'h0000_0000);
		chk("retd pc", 32'h0000_0100, rf_rdata_out);
		ev(2);
		chk("retd outside debug", 32'h0000_0001, 32'(priv_fault_out));
		$display("test masks and return done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
